// File: logic/gcs_defs.svh
// Constants for the coil scan sequencer
`ifndef GCS_DEFS_SVH
`define GCS_DEFS_SVH

// ==========================================
// Register map
`define GCS_ADDR_SSC      4'h0
`define GCS_ADDR_GER      4'h1
`define GCS_ADDR_MAG_BASE 4'h2
`define GCS_ADDR_DIR_BASE 4'h8
// ==========================================
// Scan status and control bit positions
`define GCS_BIT_IRQ_EN    7
`define GCS_BIT_FLAG      6
`define GCS_BIT_FLAG_CLR  5
`define GCS_BIT_CS_HI     4
`define GCS_BIT_CS_LO     3
`define GCS_BIT_START     2
`define GCS_BIT_AUTO      1
// ==========================================
// Reset values and counts
`define GCS_SSC_RESET     8'h00
`define GCS_GER_RESET     8'h00
`define GCS_NUM_COILS     12
`define GCS_SYNC_COIL     10
`define GCS_DIV_BASE_LOG2 9

`endif

// File: logic/gcs_pkg.sv
// Types for the coil scan sequencer
package gcs_pkg;
  typedef enum logic [1:0] {
    GCS_IDLE,
    GCS_SCAN
  } gcs_state_type;
endpackage

// File: logic/gcs_sequencer.sv
// Coil scan sequencer control, status and coil data buffering
//
// Chosen here: strobed register access and the address map.
`timescale 1ns/1ps
`include "gcs_defs.svh"

module gcs_sequencer #(
  parameter int DATA_W = 8
) (
  input  wire logic              i_sys_clk,
  input  wire logic              i_sys_rst,
  input  wire logic [3:0]        i_addr,
  input  wire logic [7:0]        i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic [7:0]             o_rdata,
  output logic                   o_irq,
  output logic [3:0]             o_coil_idx,
  output logic                   o_coil_tick,
  output logic                   o_coil_drive_en,
  output logic [DATA_W-1:0]      o_coil_mag,
  output logic                   o_coil_dir,
  output gcs_pkg::gcs_state_type o_state
);
  import gcs_pkg::*;

  // ==========================================
  // Control register
  logic        irq_en_r;
  logic        flag_r;
  logic [1:0]  clk_sel_r;
  logic        start_r;
  logic        auto_r;
  logic        flag_seen_r;
  logic [5:0]  ger_r;
  logic [11:0] div_r;
  logic        tick;
  logic [3:0]  coil_r;
  gcs_state_type state_r;
  logic        sync_hit;
  logic        wr_ssc;
  logic        start_req;
  logic [11:0] mag_wr;
  logic [11:0] dir_wr;
  logic [11:0] mag_seen_r;
  logic [5:0]  xfer;
  logic [DATA_W-1:0] mag_m_r [0:11];
  logic [DATA_W-1:0] mag_s_r [0:11];
  logic [11:0] dir_m_r;
  logic [11:0] dir_s_r;

  assign wr_ssc    = i_wr && (i_addr == `GCS_ADDR_SSC);
  // Ignored while set or in auto mode
  assign start_req = wr_ssc && i_wdata[`GCS_BIT_START] && !start_r && !auto_r;
  // Fires on the tick that moves service onto the sync coil
  assign sync_hit  = tick && (state_r == GCS_SCAN) && (coil_r == 4'(`GCS_SYNC_COIL - 1));

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      irq_en_r  <= 1'b0;
      clk_sel_r <= 2'b00;
      auto_r    <= 1'b0;
      ger_r     <= 6'h00;
    end else if (i_wr && i_addr == `GCS_ADDR_SSC) begin
      irq_en_r  <= i_wdata[`GCS_BIT_IRQ_EN];
      clk_sel_r <= i_wdata[`GCS_BIT_CS_HI:`GCS_BIT_CS_LO];
      auto_r    <= i_wdata[`GCS_BIT_AUTO];
    end else if (i_wr && i_addr == `GCS_ADDR_GER) begin
      ger_r     <= i_wdata[5:0];
    end
  end

  // ==========================================
  // Start bit
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      start_r <= 1'b0;
    end else if (sync_hit) begin
      start_r <= 1'b0;
    end else if (start_req) begin
      start_r <= 1'b1;
    end
  end

  // ==========================================
  // Sync flag; set wins over a same-cycle clear
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      flag_r      <= 1'b0;
      flag_seen_r <= 1'b0;
    end else if (sync_hit) begin
      flag_r      <= 1'b1;
      flag_seen_r <= flag_seen_r;
    end else if (wr_ssc && i_wdata[`GCS_BIT_FLAG_CLR] && flag_seen_r) begin
      flag_r      <= 1'b0;
      flag_seen_r <= 1'b0;
    end else if (i_rd && i_addr == `GCS_ADDR_SSC) begin
      flag_seen_r <= flag_r;
    end
  end

  assign o_irq = flag_r && irq_en_r;

  // ==========================================
  // Divider; code 11 is unsupported but still divides by 4096
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst || tick || (state_r == GCS_IDLE)) begin
      // Held while idle so the first slot of a scan is a full one
      div_r <= 12'h000;
    end else begin
      div_r <= div_r + 12'h001;
    end
  end

  assign tick = (div_r == 12'((1 << (`GCS_DIV_BASE_LOG2 + clk_sel_r)) - 1));

  // ==========================================
  // Scan sequence
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      state_r <= GCS_IDLE;
      coil_r  <= 4'h0;
    end else begin
      case (state_r)
        GCS_IDLE: begin
          coil_r <= 4'h0;
          if (auto_r || start_r) begin
            state_r <= GCS_SCAN;
          end
        end
        GCS_SCAN: begin
          if (tick) begin
            if (coil_r == 4'(`GCS_NUM_COILS - 1)) begin
              coil_r <= 4'h0;
              if (!auto_r) begin
                state_r <= GCS_IDLE;
              end // otherwise wrap at once
            end else begin
              coil_r <= coil_r + 4'h1;
            end
          end
        end
        default: begin
          state_r <= GCS_IDLE;
        end
      endcase
    end
  end

  // ==========================================
  // Coil data masters, slaves and write tracking
  generate
    for (genvar g = 0; g < 6; g++) begin : g_gauge
      // A gauge loads as its first coil comes up; gauge 5 thus loads with the flag, not after it
      assign xfer[g] = auto_r && tick && (state_r == GCS_SCAN)
                       && (coil_r == 4'((2 * g + 11) % 12))
                       && mag_seen_r[2*g] && mag_seen_r[2*g+1];
    end
    for (genvar c = 0; c < 12; c++) begin : g_coil
      assign mag_wr[c] = i_wr && (i_addr == 4'(`GCS_ADDR_MAG_BASE + (c / 2))) && (i_wdata[7] == 1'(c % 2));
      assign dir_wr[c] = i_wr && (i_addr == 4'(`GCS_ADDR_DIR_BASE + (c / 2 > 3 ? 3 : c / 2)))
                         && (c / 2 <= 3);

      // Write tracking for the pair rule
      always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
          mag_seen_r[c] <= 1'b0;
        end else if (mag_wr[c]) begin
          mag_seen_r[c] <= 1'b1;
        end else if (xfer[c/2]) begin
          mag_seen_r[c] <= 1'b0;
        end
      end

      // Master buffers take every write
      always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
          mag_m_r[c] <= '0;
        end else if (mag_wr[c]) begin
          mag_m_r[c] <= DATA_W'(i_wdata[6:0]);
        end
      end

      always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
          dir_m_r[c] <= 1'b0;
        end else if (dir_wr[c]) begin
          dir_m_r[c] <= i_wdata[c % 2];
        end
      end

      // Slaves load only at a start or a gauge boundary; a start written after sync loads them mid-scan
      always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
          mag_s_r[c] <= '0;
          dir_s_r[c] <= 1'b0;
        end else if (start_req) begin
          mag_s_r[c] <= mag_m_r[c];
          dir_s_r[c] <= dir_m_r[c];
        end else if (xfer[c/2]) begin
          mag_s_r[c] <= mag_m_r[c];
          dir_s_r[c] <= dir_m_r[c];
        end
      end
    end
  endgenerate

  // ==========================================
  // Coil outputs; disabled gauges keep their slot with driver off
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_coil_mag      <= '0;
      o_coil_dir      <= 1'b0;
      o_coil_drive_en <= 1'b0;
    end else begin
      o_coil_mag      <= mag_s_r[coil_r];
      o_coil_dir      <= dir_s_r[coil_r];
      o_coil_drive_en <= (state_r == GCS_SCAN) && ger_r[coil_r[3:1]];
    end
  end

  assign o_coil_idx  = coil_r;
  assign o_coil_tick = tick && (state_r == GCS_SCAN);
  assign o_state     = state_r;

  // ==========================================
  // Read data
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_rdata <= 8'h00;
    end else if (i_rd && i_addr == `GCS_ADDR_SSC) begin
      o_rdata <= {irq_en_r, flag_r, 1'b0, clk_sel_r, start_r, auto_r, 1'b0};
    end else if (i_rd && i_addr == `GCS_ADDR_GER) begin
      o_rdata <= {2'b00, ger_r};
    end else begin
      o_rdata <= 8'h00;
    end
  end
endmodule

// File: testbench/gcs_cpu.sv
// Register bus master standing in for the processor core
`timescale 1ns/1ps
module gcs_cpu (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rdata,
  output logic [3:0]      o_addr,
  output logic [7:0]      o_wdata,
  output logic            o_wr,
  output logic            o_rd
);
  initial begin
    o_addr  = 4'h0;
    o_wdata = 8'h00;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_wr    <= 1'b1;
    o_addr  <= a;
    o_wdata <= d;
    @(posedge i_clk);
    o_wr <= 1'b0;
  endtask
  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_clk);
    o_rd   <= 1'b1;
    o_addr <= a;
    @(posedge i_clk);
    o_rd <= 1'b0;
    #1 d = i_rdata;
  endtask
endmodule

// File: testbench/gcs_sequencer_asserts.sv
// Port checks for the coil scan sequencer
`timescale 1ns/1ps
`include "gcs_defs.svh"
module gcs_asserts (
  input wire logic                   i_sys_clk,
  input wire logic                   i_sys_rst,
  input wire logic [3:0]             i_addr,
  input wire logic [7:0]             i_wdata,
  input wire logic                   i_wr,
  input wire logic                   i_rd,
  input wire logic [7:0]             o_rdata,
  input wire logic                   o_irq,
  input wire logic [3:0]             o_coil_idx,
  input wire logic                   o_coil_drive_en,
  input wire gcs_pkg::gcs_state_type o_state
);
  import gcs_pkg::*;
  default clocking dc @(posedge i_sys_clk);
  endclocking
  default disable iff (i_sys_rst);
  // ==========================================
  // Manual start
  sequence s_start;
    i_wr && i_addr == `GCS_ADDR_SSC && i_wdata[2] && !i_wdata[1] && o_state == GCS_IDLE;
  endsequence
  sequence s_scan;
    o_state == GCS_SCAN;
  endsequence
  a_manual_start: assert property (s_start |-> ##[1:3] s_scan) else $error("no scan after start");
  a_coil_range: assert property (o_coil_idx <= 4'hB) else $error("coil index out of range");
  a_idx_step: assert property ($changed(o_coil_idx) |-> o_coil_idx == $past(o_coil_idx) + 4'h1 ||
    o_coil_idx == 4'h0) else $error("coil order broken");
  a_rdata_idle: assert property (!i_rd |=> o_rdata == 8'h00) else $error("read data without read");
  a_clr_reads0: assert property (i_rd && i_addr == `GCS_ADDR_SSC |=> !o_rdata[5]) else $error("clear bit read 1");
  a_irq_masked: assert property (i_wr && i_addr == `GCS_ADDR_SSC && !i_wdata[7] |=> !o_irq)
    else $error("request while disabled");
  a_irq_cause: assert property ($rose(o_irq) |-> o_coil_idx == 4'hA || $past(i_wr))
    else $error("request without cause");
  a_idle_off: assert property (o_state == GCS_IDLE && $past(o_state) == GCS_IDLE |-> !o_coil_drive_en)
    else $error("driver on while idle");
endmodule
bind gcs_sequencer gcs_asserts gcs_asserts_i (.*);

// File: testbench/tb.sv
// Self-checking bench for the coil scan sequencer
`timescale 1ns/1ps
`include "gcs_defs.svh"
module tb;
  import gcs_pkg::*;
  logic          clk, rst, wr, rd, irq, drv;
  logic [3:0]    addr, idx;
  logic [7:0]    wd, rdat, d, mag;
  gcs_state_type st;
  int            bad_count = 0;
  int            total_checks = 0;
  int            n;
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  gcs_sequencer gcs_sequencer_i (.i_sys_clk(clk), .i_sys_rst(rst), .i_addr(addr), .i_wdata(wd), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdat), .o_irq(irq), .o_coil_idx(idx), .o_coil_tick(), .o_coil_drive_en(drv),
    .o_coil_mag(mag), .o_coil_dir(), .o_state(st));
  gcs_cpu gcs_cpu_i (.i_clk(clk), .i_rdata(rdat), .o_addr(addr), .o_wdata(wd), .o_wr(wr), .o_rd(rd));
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wait_idx(input logic [3:0] v);
    n = 0;
    while (idx !== v && n < 30000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 30000) bad_count++;
  endtask
  task automatic finish_test();
    if (bad_count == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset();
    gcs_cpu_i.rd(`GCS_ADDR_SSC, d);
    chk("ssc reset", d, 8'h00);
    gcs_cpu_i.rd(4'hF, d);
    chk("unmapped", d, 8'h00);
  endtask
  // Code 11 is never used: divide by 4096 is forbidden to software
  task automatic t_manual(input logic [1:0] sel);
    gcs_cpu_i.wr(`GCS_ADDR_GER, 8'h3F);
    gcs_cpu_i.wr(`GCS_ADDR_SSC, {3'b100, sel, 3'b100});
    gcs_cpu_i.wr(`GCS_ADDR_SSC, {3'b100, sel, 3'b100});
    wait_idx(4'hA);
    chk("slot", 8'((n > 10 * (512 << sel) - 6) && (n < 10 * (512 << sel) + 4)), 8'h01);
    gcs_cpu_i.wr(`GCS_ADDR_SSC, {3'b101, sel, 3'b000});
    gcs_cpu_i.rd(`GCS_ADDR_SSC, d);
    chk("flag start", d & 8'h64, 8'h40);
    chk("irq", {7'h00, irq}, 8'h01);
    gcs_cpu_i.wr(`GCS_ADDR_MAG_BASE, 8'h00);
    gcs_cpu_i.wr(`GCS_ADDR_SSC, {3'b101, sel, 3'b000});
    gcs_cpu_i.rd(`GCS_ADDR_SSC, d);
    chk("flag clr", d & 8'h40, 8'h00);
    chk("irq off", {7'h00, irq}, 8'h00);
    wait_idx(4'hB);
    repeat (3 * (512 << sel)) @(posedge clk);
    chk("idle", 8'(st), 8'(GCS_IDLE));
  endtask
  task automatic t_auto();
    gcs_cpu_i.wr(`GCS_ADDR_GER, 8'h00);
    gcs_cpu_i.wr(`GCS_ADDR_MAG_BASE, 8'h15);
    gcs_cpu_i.wr(`GCS_ADDR_MAG_BASE, 8'h9A);
    gcs_cpu_i.wr(`GCS_ADDR_SSC, 8'h02);
    n = 0;
    repeat (13 * 512) @(posedge clk) if (drv !== 1'b0) n++;
    chk("disabled", 8'(n), 8'h00);
    chk("auto run", 8'(st), 8'(GCS_SCAN));
    gcs_cpu_i.rd(`GCS_ADDR_SSC, d);
    chk("auto flag", d & 8'h40, 8'h40);
    wait_idx(4'h2);
    wait_idx(4'h1);
    repeat (2) @(posedge clk);
    chk("auto mag", mag, 8'h1A);
  endtask
  initial begin
    rst = 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    for (int s = 0; s < 3; s++) t_manual(2'(s));
    t_auto();
    finish_test();
  end
  // Bound by the longest expected run with ample margin
  initial begin
    #2400000;
    bad_count++;
    finish_test();
  end
endmodule
